// ==== design/rxpf_params.svh ====
// register offsets, field positions and reset values of the rx packet format block
`ifndef RXPF_PARAMS_SVH
`define RXPF_PARAMS_SVH

// index offsets are not multiples of four: byte address is index times four
`define RXPF_IDX_PKT_CTRL     8'h30
`define RXPF_IDX_HDR_CTRL2    8'h33
`define RXPF_IDX_PREA_LEN     8'h34
`define RXPF_IDX_PREA_DET     8'h35
`define RXPF_IDX_SYNC3        8'h36
`define RXPF_IDX_SYNC2        8'h37
`define RXPF_IDX_SYNC1        8'h38
`define RXPF_IDX_SYNC0        8'h39
`define RXPF_IDX_FIX_LEN      8'h3E
`define RXPF_IDX_STATUS       8'h50

`define RXPF_RST_HDR_CTRL2    8'h00
`define RXPF_RST_PREA_LEN     8'h08
`define RXPF_RST_PREA_DET     8'h00
`define RXPF_RST_SYNC3        8'h2D
`define RXPF_RST_SYNC2        8'hD4
`define RXPF_RST_SYNC1        8'h00
`define RXPF_RST_SYNC0        8'h00
`define RXPF_RST_FIX_LEN      8'h00
`define RXPF_RST_PKT_EN       1'b0

`define RXPF_HDR2_WMASK       8'h7F
`define RXPF_PKT_EN_BIT       7
`define RXPF_MAX_HDR_CODE     3'h4

`endif

// ==== design/rxpf_pkg.sv ====
// types shared by the rx packet format block
package rxpf_pkg;

	typedef struct packed {
		logic       pkt_en;
		logic [2:0] hdr_len;
		logic       fixed_len;
		logic [1:0] sync_len;
		logic [8:0] prea_len;
		logic [4:0] prea_thresh;
		logic [2:0] rssi_offset;
		logic [7:0] fixed_len_val;
	} rxpf_cfg_t;

	typedef enum logic [4:0] {
		RXPF_HUNT   = 5'b00001,
		RXPF_HEADER = 5'b00010,
		RXPF_LENGTH = 5'b00100,
		RXPF_BODY   = 5'b01000,
		RXPF_DONE   = 5'b10000
	} rxpf_state_t;

endpackage : rxpf_pkg

// ==== design/rxpf_top.sv ====
// rx packet format configuration registers with sync, header and length framer
//
// Contract
// - header length counts only while packet handling is enabled.
// - header bytes arrive index 3 first; code 0 none up to code 4 bytes 3..0.
// - fixed-length set means no length byte and the configured length is used.
// - sync length code 0..3 selects byte 3 only up to all four bytes.
// - sync bytes are expected highest index first.
// - preamble length is nine bits counting 4-bit nibbles.
// - preamble length bit 8 lives in bit 0 of header control two.
// - a preamble length of zero acts as one nibble.
// - the largest preamble length is all nine bits set.
// - preamble length resets to eight nibbles.
// - a five-bit threshold in bits 7:3 of detect control counts nibbles.
// - a three-bit field in bits 2:0 adds 4 dB per step to signal strength.
// - sync bytes 3, 2, 1 reset to 2D, D4 and 00.
// - with packet handling off every byte after sync is stored as body.
//
// Local design decision: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "rxpf_params.svh"

module rxpf_top
	import rxpf_pkg::*;
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// demodulated byte stream
	input  wire logic [7:0]  rx_byte,
	input  wire logic        rx_byte_valid,
	input  wire logic        rx_frame_end,
	// framer outputs and static configuration outputs
	output logic [7:0]       body_byte,
	output logic             body_valid,
	output logic             hdr_valid,
	output logic [1:0]       hdr_index,
	output logic             sync_found,
	output logic [8:0]       prea_nibbles,
	output logic [4:0]       prea_thresh,
	output logic [5:0]       rssi_offset_db
);

	// ----------------------------------------------------------
	// registers
	// ----------------------------------------------------------
	logic [7:0] hdr_ctrl2;
	logic [7:0] prea_len_lo;
	logic [7:0] prea_det;
	logic [7:0] sync_w [0:3];
	logic [7:0] fix_len;
	logic       pkt_en;

	rxpf_cfg_t   cfg;
	rxpf_state_t state;
	rxpf_state_t next_state;

	logic [1:0] sync_idx;
	logic [2:0] hdr_cnt;
	logic [7:0] body_cnt;
	logic       body_limited;
	logic [7:0] len_val;

	// ----------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------
	logic [9:0] idx;
	logic       wr_en;
	logic       rd_en;
	logic       addr_ok;
	logic [7:0] wbyte;
	logic [7:0] rd_val;

	assign idx   = paddr[11:2];
	assign wbyte = pwdata[7:0];
	assign wr_en = psel && penable && pwrite && pstrb[0] && addr_ok;
	assign rd_en = psel && !penable && !pwrite;

	always_comb begin
		addr_ok = 1'b1;
		rd_val  = 8'h00;
		case (idx)
			{2'b00, `RXPF_IDX_PKT_CTRL}:  rd_val = {pkt_en, 7'h00};
			{2'b00, `RXPF_IDX_HDR_CTRL2}: rd_val = {1'b0, hdr_ctrl2[6:0]};
			{2'b00, `RXPF_IDX_PREA_LEN}:  rd_val = prea_len_lo;
			{2'b00, `RXPF_IDX_PREA_DET}:  rd_val = prea_det;
			{2'b00, `RXPF_IDX_SYNC3}:     rd_val = sync_w[3];
			{2'b00, `RXPF_IDX_SYNC2}:     rd_val = sync_w[2];
			{2'b00, `RXPF_IDX_SYNC1}:     rd_val = sync_w[1];
			{2'b00, `RXPF_IDX_SYNC0}:     rd_val = sync_w[0];
			{2'b00, `RXPF_IDX_FIX_LEN}:   rd_val = fix_len;
			{2'b00, `RXPF_IDX_STATUS}:    rd_val = {3'h0, state};
			default:                      addr_ok = 1'b0;
		endcase
	end

	// zero-wait slave: every access completes in its first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !addr_ok;
			if (rd_en)
				prdata <= {24'h00_0000, rd_val};
		end
	end

	// ----------------------------------------------------------
	// register writes (taken at the access edge with pready high)
	// ----------------------------------------------------------
	logic wr_take;
	assign wr_take = wr_en && pready;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hdr_ctrl2   <= `RXPF_RST_HDR_CTRL2;
			prea_len_lo <= `RXPF_RST_PREA_LEN;
			prea_det    <= `RXPF_RST_PREA_DET;
			sync_w[3]   <= `RXPF_RST_SYNC3;
			sync_w[2]   <= `RXPF_RST_SYNC2;
			sync_w[1]   <= `RXPF_RST_SYNC1;
			sync_w[0]   <= `RXPF_RST_SYNC0;
			fix_len     <= `RXPF_RST_FIX_LEN;
			pkt_en      <= `RXPF_RST_PKT_EN;
		end else if (wr_take) begin
			case (idx)
				{2'b00, `RXPF_IDX_PKT_CTRL}:
					pkt_en <= wbyte[`RXPF_PKT_EN_BIT];
				{2'b00, `RXPF_IDX_HDR_CTRL2}:
					hdr_ctrl2 <= wbyte & `RXPF_HDR2_WMASK;
				{2'b00, `RXPF_IDX_PREA_LEN}:  prea_len_lo <= wbyte;
				{2'b00, `RXPF_IDX_PREA_DET}:  prea_det    <= wbyte;
				{2'b00, `RXPF_IDX_SYNC3}:     sync_w[3]   <= wbyte;
				{2'b00, `RXPF_IDX_SYNC2}:     sync_w[2]   <= wbyte;
				{2'b00, `RXPF_IDX_SYNC1}:     sync_w[1]   <= wbyte;
				{2'b00, `RXPF_IDX_SYNC0}:     sync_w[0]   <= wbyte;
				{2'b00, `RXPF_IDX_FIX_LEN}:   fix_len     <= wbyte;
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------
	// configuration view
	// ----------------------------------------------------------
	always_comb begin
		cfg.pkt_en        = pkt_en;
		cfg.hdr_len       = hdr_ctrl2[6:4];
		cfg.fixed_len     = hdr_ctrl2[3];
		cfg.sync_len      = hdr_ctrl2[2:1];
		cfg.prea_len      = {hdr_ctrl2[0], prea_len_lo};
		cfg.prea_thresh   = prea_det[7:3];
		cfg.rssi_offset   = prea_det[2:0];
		cfg.fixed_len_val = fix_len;
	end

	// header byte count in effect; codes above four clamp to four
	logic [2:0] hdr_need;
	always_comb begin
		if (!cfg.pkt_en)
			hdr_need = 3'h0;
		else if (cfg.hdr_len > `RXPF_MAX_HDR_CODE)
			hdr_need = `RXPF_MAX_HDR_CODE;
		else
			hdr_need = cfg.hdr_len;
	end

	// ----------------------------------------------------------
	// static outputs
	// ----------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prea_nibbles   <= {1'b0, `RXPF_RST_PREA_LEN};
			prea_thresh    <= 5'h00;
			rssi_offset_db <= 6'h00;
		end else begin
			// zero behaves as one nibble
			prea_nibbles <= (cfg.prea_len == 9'h000) ? 9'h001
				: cfg.prea_len;
			prea_thresh    <= cfg.prea_thresh;
			rssi_offset_db <= {1'b0, cfg.rssi_offset, 2'b00};
		end
	end

	// ----------------------------------------------------------
	// framer state machine
	// ----------------------------------------------------------
	logic sync_hit;
	logic sync_last;
	logic hdr_last;
	assign sync_hit  = rx_byte == sync_w[2'h3 - sync_idx];
	assign sync_last = sync_idx == cfg.sync_len;
	assign hdr_last  = (hdr_cnt + 3'h1) == hdr_need;

	always_comb begin
		next_state = state;
		case (state)
			RXPF_HUNT:
				if (rx_byte_valid && sync_hit && sync_last) begin
					if (hdr_need != 3'h0)
						next_state = RXPF_HEADER;
					else if (cfg.pkt_en && !cfg.fixed_len)
						next_state = RXPF_LENGTH;
					else
						next_state = RXPF_BODY;
				end
			RXPF_HEADER:
				if (rx_byte_valid && hdr_last)
					next_state = cfg.fixed_len ? RXPF_BODY
						: RXPF_LENGTH;
			RXPF_LENGTH:
				if (rx_byte_valid)
					next_state = (rx_byte == 8'h00) ? RXPF_DONE : RXPF_BODY;
			RXPF_BODY:
				if (rx_byte_valid && body_limited
					&& body_cnt + 8'h01 == len_val)
					next_state = RXPF_DONE;
			RXPF_DONE:
				next_state = RXPF_DONE;
			default:
				next_state = RXPF_HUNT;
		endcase
		if (rx_frame_end)
			next_state = RXPF_HUNT;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state <= RXPF_HUNT;
		else
			state <= next_state;
	end

	// sync byte index: restart on mismatch, rechecking the byte as byte 3
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			sync_idx <= 2'h0;
		else if (state != RXPF_HUNT || rx_frame_end)
			sync_idx <= 2'h0;
		else if (rx_byte_valid) begin
			if (sync_hit && !sync_last)
				sync_idx <= sync_idx + 2'h1;
			else if (!sync_hit && rx_byte == sync_w[3] && cfg.sync_len != 2'h0)
				sync_idx <= 2'h1;
			else
				sync_idx <= 2'h0;
		end
	end

	// header count, length capture and body count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hdr_cnt      <= 3'h0;
			body_cnt     <= 8'h00;
			len_val      <= 8'h00;
			body_limited <= 1'b0;
		end else if (state == RXPF_HUNT) begin
			hdr_cnt      <= 3'h0;
			body_cnt     <= 8'h00;
			len_val      <= cfg.fixed_len_val;
			body_limited <= cfg.pkt_en;
		end else if (rx_byte_valid) begin
			if (state == RXPF_HEADER)
				hdr_cnt <= hdr_cnt + 3'h1;
			if (state == RXPF_LENGTH)
				len_val <= rx_byte;
			if (state == RXPF_BODY)
				body_cnt <= body_cnt + 8'h01;
		end
	end

	// registered outputs toward the data path
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			body_byte  <= 8'h00;
			body_valid <= 1'b0;
			hdr_valid  <= 1'b0;
			hdr_index  <= 2'h0;
			sync_found <= 1'b0;
		end else begin
			body_byte  <= rx_byte;
			body_valid <= rx_byte_valid && state == RXPF_BODY
				&& !rx_frame_end;
			hdr_valid  <= rx_byte_valid && state == RXPF_HEADER
				&& !rx_frame_end;
			hdr_index  <= 2'(3'h3 - hdr_cnt);
			sync_found <= state == RXPF_HUNT && next_state != RXPF_HUNT;
		end
	end

endmodule : rxpf_top
`default_nettype wire

// ==== testbench/rxpf_top_chk.sv ====
// assertion checker for the rx packet format block
`timescale 1ns/100ps
`default_nettype none
module rxpf_top_chk (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	input wire logic       rx_byte_valid,
	input wire logic       rx_frame_end,
	input wire logic       body_valid,
	input wire logic       hdr_valid,
	input wire logic [1:0] hdr_index,
	input wire logic       sync_found,
	input wire logic [8:0] prea_nibbles,
	input wire logic [5:0] rssi_offset_db
);
	logic       in_frame;
	logic       hdr_first;
	logic [1:0] last_idx;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_frame <= 1'b0;
			hdr_first <= 1'b0;
		end else if (rx_frame_end) begin
			in_frame <= 1'b0;
			hdr_first <= 1'b0;
		end else if (sync_found) begin
			in_frame <= 1'b1;
			hdr_first <= 1'b1;
		end else if (hdr_valid)
			hdr_first <= 1'b0;
	end
	always_ff @(posedge pclk)
		if (hdr_valid)
			last_idx <= hdr_index;
	chk_apb_answer: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	chk_link_quiet: assert property (!rx_byte_valid |=>
		!(body_valid || hdr_valid || sync_found))
		else $error("framer output without a byte");
	chk_sync_single: assert property (sync_found |=> !sync_found [*2])
		else $error("sync found repeated");
	chk_body_synced: assert property (body_valid |-> in_frame)
		else $error("body before sync");
	chk_hdr_synced: assert property (hdr_valid |-> in_frame)
		else $error("header before sync");
	chk_hdr_first: assert property (hdr_valid && hdr_first |-> hdr_index == 2'h3)
		else $error("first header index not 3");
	chk_hdr_order: assert property (hdr_valid && !hdr_first |->
		hdr_index == last_idx - 2'h1)
		else $error("header index not descending");
	chk_prea_min: assert property (prea_nibbles != 9'h000)
		else $error("preamble shown as zero");
	chk_rssi_step: assert property (rssi_offset_db[1:0] == 2'h0 &&
		rssi_offset_db <= 6'h1C)
		else $error("rssi offset not in 4 dB steps");
	cov_sync: cover property (sync_found);
	cov_hdr_last: cover property (hdr_valid && hdr_index == 2'h0);
	cov_body: cover property (body_valid ##2 body_valid);
endmodule : rxpf_top_chk
bind rxpf_top rxpf_top_chk i_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pready(pready),
	.rx_byte_valid(rx_byte_valid), .rx_frame_end(rx_frame_end),
	.body_valid(body_valid), .hdr_valid(hdr_valid), .hdr_index(hdr_index),
	.sync_found(sync_found), .prea_nibbles(prea_nibbles),
	.rssi_offset_db(rssi_offset_db));
`default_nettype wire

// ==== testbench/rxpf_link_src.sv ====
// byte source standing in for the demodulator
`timescale 1ns/100ps
`default_nettype none
module rxpf_link_src (
	input  wire logic       pclk,
	output var  logic [7:0] rx_byte,
	output var  logic       rx_byte_valid,
	output var  logic       rx_frame_end
);
	int gap = 0;
	initial begin
		rx_byte = 8'hA5;
		rx_byte_valid = 1'b0;
		rx_frame_end = 1'b0;
	end
	task send(input logic [7:0] b);
		@(posedge pclk);
		rx_byte <= b;
		rx_byte_valid <= 1'b1;
		@(posedge pclk);
		rx_byte_valid <= 1'b0;
		// idle line shows the complement, never a stale copy
		rx_byte <= ~b;
		repeat (gap) @(posedge pclk);
	endtask : send
	task send_sync(input logic [31:0] sw, input int n);
		for (int i = 3; i > 3 - n; i--)
			send(sw[i*8 +: 8]);
	endtask : send_sync
	task end_frame();
		@(posedge pclk);
		rx_frame_end <= 1'b1;
		@(posedge pclk);
		rx_frame_end <= 1'b0;
	endtask : end_frame
endmodule : rxpf_link_src
`default_nettype wire

// ==== testbench/rxpf_top_tb.sv ====
// self-checking bench for the rx packet format block
`timescale 1ns/100ps
`default_nettype none
module rxpf_top_tb;
	logic        pclk = 1'b0, presetn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q, sw;
	logic [3:0]  pstrb = 4'hF;
	logic        pready, pslverr, body_valid, hdr_valid, sync_found, e;
	logic [7:0]  rx_byte, body_byte, bx = 8'h00;
	logic        rx_byte_valid, rx_frame_end;
	logic [1:0]  hdr_index;
	logic [8:0]  prea_nibbles;
	logic [4:0]  prea_thresh;
	logic [5:0]  rssi_offset_db;
	logic [31:0] s = 32'h0000_2C0D;
	int          failures = 0, check_count = 0, cyc = 0;
	int          ns = 0, nh = 0, nb = 0;
	rxpf_top i_dut (.*);
	rxpf_link_src i_src (.*);
	always #2 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		ns += sync_found;
		nh += hdr_valid;
		nb += body_valid;
		if (body_valid)
			bx ^= body_byte;
		if (cyc == 5000) begin
			failures++;
			finish_test();
		end
	end
	function logic [7:0] rnd();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s[7:0];
	endfunction : rnd
	function logic [8:0] prea_exp(logic [8:0] v);
		return (v == 9'h000) ? 9'h001 : v;
	endfunction : prea_exp
	task chk(string nm, logic [31:0] got, logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("FAIL %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	task apb(logic w, logic [7:0] idx, logic [7:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		// a slave that never answers counts as a mismatch
		if (pready !== 1'b1)
			failures++;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	initial begin
		logic [7:0] rv [6];
		logic [7:0] h, l, d, b, ex;
		logic       pe, fx;
		int         nhx, nbx;
		rv = '{8'h00, 8'h08, 8'h00, 8'h2D, 8'hD4, 8'h00};
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("prea_nibbles", prea_nibbles, 9'h008);
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, 8'(8'h33 + i), 8'h00);
			chk("reset value", q, rv[i]);
		end
		$display("test reset done");
		for (int k = 0; k < 8; k++) begin
			h = (k == 0) ? 8'h80 : (k == 1) ? 8'hFF : rnd();
			l = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : rnd();
			d = rnd();
			apb(1'b1, 8'h33, h);
			apb(1'b1, 8'h34, l);
			apb(1'b1, 8'h35, d);
			apb(1'b0, 8'h33, 8'h00);
			chk("hdr ctrl two", q, h & 8'h7F);
			chk("prea_nibbles", prea_nibbles, prea_exp({h[0], l}));
			chk("prea_thresh", prea_thresh, d[7:3]);
			chk("rssi_offset_db", rssi_offset_db, d[2:0] * 4);
		end
		pstrb <= 4'hE;
		apb(1'b1, 8'h34, ~l);
		pstrb <= 4'hF;
		apb(1'b0, 8'h34, 8'h00);
		chk("strobe off", q, l);
		apb(1'b0, 8'h3A, 8'h00);
		chk("unmapped", {e, q[30:0]}, 32'h80000000);
		$display("test config done");
		for (int k = 0; k < 11; k++) begin
			pe = k > 3;
			fx = k == 9;
			sw = {rnd(), rnd(), rnd(), rnd()};
			for (int i = 0; i < 4; i++)
				apb(1'b1, 8'(8'h36 + i), sw[31 - 8*i -: 8]);
			apb(1'b1, 8'h30, {pe, 7'h00});
			// handling off still carries a header code that must be ignored
			apb(1'b1, 8'h33, {1'b0, 3'(pe ? k - 4 : k + 1), fx, 2'(k), 1'b0});
			apb(1'b1, 8'h3E, 8'h03);
			nhx = (pe && k < 10) ? ((k > 8) ? 4 : k - 4) : 0;
			nbx = (k == 10) ? 0 : !pe ? 5 : fx ? 3 : 2;
			ns = 0;
			nh = 0;
			nb = 0;
			bx = 8'h00;
			ex = 8'h00;
			i_src.gap = rnd() % 3;
			// last frame breaks its final sync byte and must stay silent
			i_src.send_sync((k == 10) ? sw ^ 32'h100 : sw, (k % 4) + 1);
			for (int i = 0; i < nhx; i++)
				i_src.send(rnd());
			if (pe && !fx && k < 10)
				i_src.send(8'h02);
			for (int i = 0; i < nbx; i++) begin
				b = rnd();
				ex ^= b;
				i_src.send(b);
			end
			i_src.end_frame();
			repeat (3) @(posedge pclk);
			chk("sync_found", ns, k < 10);
			chk("hdr_valid", nh, nhx);
			chk("body_valid", nb, nbx);
			chk("body_byte", bx, ex);
		end
		$display("test frames done");
		finish_test();
	end
	task finish_test();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : finish_test
endmodule : rxpf_top_tb
`default_nettype wire
